// ---- pc_skip_pkg.sv ----
package pc_skip_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned PC_W   = 13;
   localparam int unsigned PCH_W  = 5;
   localparam int unsigned ROM_W  = 16;

   localparam logic [7:0] LOW_PTR_ADDR  = 8'h80;
   localparam logic [7:0] HIGH_PTR_ADDR = 8'h81;
   localparam logic [7:0] RESULT_ADDR   = 8'h82;
   localparam logic [7:0] SEC_LOW_ADDR  = 8'h83;
   localparam logic [7:0] SEC_HIGH_ADDR = 8'h84;
   localparam logic [7:0] AUX_ADDR      = 8'h85;

   localparam logic [7:0]  AUX_RST   = 8'h00;
   localparam logic [7:0]  UNMAPPED  = 8'h00;
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [12:0] STEP      = 13'h0001;
   localparam logic [12:0] SKIP_STEP = 13'h0002;
   localparam logic [7:0]  BYTE_MAX  = 8'hff;
   localparam logic [7:0]  BYTE_MIN  = 8'h00;
   localparam logic [7:0]  BYTE_ONE  = 8'h01;

   typedef enum logic [3:0] {
      op_hold,
      op_step,
      op_jump,
      compare_skip_op,
      inc_acc_skip_op,
      inc_mem_skip_op,
      dec_acc_skip_op,
      dec_mem_skip_op,
      op_add_pcl,
      op_adc_pcl,
      bank0_add_op,
      op_sub_pcl,
      op_move_pcl,
      table_lookup_op
   } op_type;

endpackage

// ---- skip_eval.sv ----
`timescale 1ns/1ps
module skip_eval (
   input  pc_skip_pkg::op_type op_i,
   input  logic [7:0]          acc_i,
   input  logic [7:0]          operand_i,
   output logic [7:0]          result_o,
   output logic                skip_o,
   output logic                to_acc_o,
   output logic                to_mem_o
);
   import pc_skip_pkg::*;

   // wrap test shared by the four counting forms
   function automatic logic wraps(input logic [7:0] v, input logic up);
      wraps = up ? (v == BYTE_MAX) : (v == BYTE_MIN);
   endfunction

   always_comb begin
      result_o = BYTE_MIN;
      skip_o   = 1'b0;
      to_acc_o = 1'b0;
      to_mem_o = 1'b0;
      case (op_i)
         compare_skip_op: begin
            skip_o = (acc_i == operand_i); // see RL1
         end
         inc_acc_skip_op: begin
            result_o = acc_i + BYTE_ONE;
            skip_o   = wraps(acc_i, 1'b1); // see RL2
            to_acc_o = 1'b1; // see RL15
         end
         inc_mem_skip_op: begin
            result_o = operand_i + BYTE_ONE;
            skip_o   = wraps(operand_i, 1'b1); // see RL2
            to_mem_o = 1'b1; // see RL15
         end
         dec_acc_skip_op: begin
            result_o = acc_i - BYTE_ONE;
            skip_o   = wraps(acc_i, 1'b0); // see RL3
            to_acc_o = 1'b1; // see RL15
         end
         dec_mem_skip_op: begin
            result_o = operand_i - BYTE_ONE;
            skip_o   = wraps(operand_i, 1'b0); // see RL3
            to_mem_o = 1'b1; // see RL15
         end
         default: begin
            skip_o = 1'b0;
         end
      endcase
   end
endmodule

// ---- pc_unit.sv ----
`timescale 1ns/1ps
module pc_unit (
   input  logic                mclk_i,
   input  logic                rst_i,
   input  logic                op_valid_i,
   input  pc_skip_pkg::op_type op_i,
   input  logic [7:0]          acc_i,
   input  logic                carry_i,
   input  logic                skip_i,
   input  logic [12:0]         jump_addr_i,
   output logic [12:0]         pc_o
);
   import pc_skip_pkg::*;

   logic [12:0] pc_q;
   logic [12:0] pc_d;
   logic [8:0]  sum;
   logic [4:0]  counter_high_byte;
   logic [7:0]  counter_low_byte;

   assign counter_high_byte  = pc_q[12:8];
   assign counter_low_byte  = pc_q[7:0];
   assign pc_o = pc_q;

   // nine-bit add so the carry into the high byte is visible
   function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
      add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
   endfunction

   always_comb begin
      pc_d = pc_q;
      sum  = 9'h000;
      if (op_valid_i) begin
         case (op_i)
            op_hold: pc_d = pc_q;
            op_jump: pc_d = jump_addr_i; // see RL13
            compare_skip_op, inc_acc_skip_op, inc_mem_skip_op, dec_acc_skip_op, dec_mem_skip_op: begin
               pc_d = pc_q + (skip_i ? SKIP_STEP : STEP); // see RL1, see RL15
            end
            op_add_pcl, bank0_add_op: begin
               sum  = add9(counter_low_byte, acc_i, 1'b0);
               pc_d = {counter_high_byte + {4'h0, sum[8]}, sum[7:0]}; // see RL4
            end
            op_adc_pcl: begin
               sum  = add9(counter_low_byte, acc_i, carry_i);
               pc_d = {counter_high_byte + {4'h0, sum[8]}, sum[7:0]}; // see RL4
            end
            op_sub_pcl: begin
               // a borrow is dropped on purpose: the high byte only counts up
               pc_d = {counter_high_byte, counter_low_byte - acc_i}; // see RL5
            end
            op_move_pcl: pc_d = {counter_high_byte, acc_i}; // see RL6
            default: pc_d = pc_q + STEP; // see RL13
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_q <= PC_RST; // see RL13
      end else begin
         pc_q <= pc_d;
      end
   end
endmodule

// ---- pc_skip_and_pointer_regs.sv ----
`timescale 1ns/1ps
// How it works
// RL1: compare equal to operand advances the counter by two, skipping one instruction.
// RL2: increment wrapping 0xff to 0x00 skips; result to accumulator or memory.
// RL3: decrement wrapping 0x00 to 0xff skips; result to accumulator or memory.
// RL4: adds into counter low byte carry one into the high byte.
// RL5: high byte never counts down; a borrow from the low byte is dropped.
// RL6: plain move into low byte jumps to unchanged high byte and new low.
// RL7: first pointer pair is two 8-bit read/write working registers.
// RL8: first pair indirect access: bank from high byte, location from low byte.
// RL9: second pair indirect access: bank from upper byte, location from lower.
// RL10: auxiliary 8-bit register, read/write, cleared at reset, a ROM pointer.
// RL11: second pointer pair also addresses ROM for table look-up.
// RL12: look-up puts ROM high byte in result register, low byte in accumulator.
// RL13: 13-bit counter, 5-bit high and 8-bit low, steps, loads, clears.
// RL14: pointer bytes and result register get no reset value.
// RL15: a skip drops one slot; the skip instruction's result is always written.
module pc_skip_and_pointer_regs (
   input  logic                mclk_i,
   input  logic                rst_i,
   input  logic                op_valid_i,
   input  pc_skip_pkg::op_type op_i,
   input  logic [7:0]          acc_i,
   input  logic [7:0]          operand_i,
   input  logic                carry_i,
   input  logic [12:0]         jump_addr_i,
   input  logic [15:0]         rom_word_i,
   input  logic                reg_we_i,
   input  logic [7:0]          reg_waddr_i,
   input  logic [7:0]          reg_wdata_i,
   input  logic [7:0]          reg_raddr_i,
   input  logic                ptr_sel_i,
   output logic [12:0]         pc_o,
   output logic                skip_o,
   output logic                acc_we_o,
   output logic [7:0]          acc_data_o,
   output logic                mem_we_o,
   output logic [7:0]          mem_data_o,
   output logic [7:0]          reg_rdata_o,
   output logic [7:0]          ram_bank_o,
   output logic [7:0]          ram_loc_o,
   output logic [15:0]         rom_addr_o,
   output logic [7:0]          aux_ptr_o
);
   import pc_skip_pkg::*;

   logic [7:0]  low_q;
   logic [7:0]  low_d;
   logic [7:0]  high_q;
   logic [7:0]  high_d;
   logic [7:0]  result_q;
   logic [7:0]  result_d;
   logic [7:0]  sec_low_q;
   logic [7:0]  sec_low_d;
   logic [7:0]  sec_high_q;
   logic [7:0]  sec_high_d;
   logic [7:0]  aux_q;
   logic [7:0]  aux_d;

   logic        skip_q;
   logic        skip_d;
   logic        acc_we_q;
   logic        acc_we_d;
   logic [7:0]  acc_data_q;
   logic [7:0]  acc_data_d;
   logic        mem_we_q;
   logic        mem_we_d;
   logic [7:0]  mem_data_q;
   logic [7:0]  mem_data_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic [7:0]  bank_q;
   logic [7:0]  bank_d;
   logic [7:0]  loc_q;
   logic [7:0]  loc_d;
   logic [15:0] rom_q;
   logic [15:0] rom_d;

   logic [7:0]  eval_result;
   logic        eval_skip;
   logic        eval_to_acc;
   logic        eval_to_mem;
   logic        lookup;
   op_type      op_eff;
   logic [3:0]  ptr_written_q;
   logic [3:0]  ptr_written_d;

   // an idle slot must not move the counter or fire the evaluator
   assign op_eff = op_valid_i ? op_i : op_hold;
   assign lookup = op_valid_i && (op_i == table_lookup_op);

   skip_eval u_skip_eval (
      .op_i      (op_eff),
      .acc_i     (acc_i),
      .operand_i (operand_i),
      .result_o  (eval_result),
      .skip_o    (eval_skip),
      .to_acc_o  (eval_to_acc),
      .to_mem_o  (eval_to_mem)
   );

   pc_unit u_pc_unit (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .op_valid_i  (op_valid_i),
      .op_i        (op_i),
      .acc_i       (acc_i),
      .carry_i     (carry_i),
      .skip_i      (eval_skip),
      .jump_addr_i (jump_addr_i),
      .pc_o        (pc_o)
   );

   function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] l, input logic [7:0] h,
                                           input logic [7:0] r, input logic [7:0] z, input logic [7:0] y,
                                           input logic [7:0] x);
      case (a)
         LOW_PTR_ADDR:  read_reg = l;
         HIGH_PTR_ADDR: read_reg = h;
         RESULT_ADDR:   read_reg = r;
         SEC_LOW_ADDR:  read_reg = z;
         SEC_HIGH_ADDR: read_reg = y;
         AUX_ADDR:      read_reg = x;
         default:       read_reg = UNMAPPED;
      endcase
   endfunction

   // working register file
   always_comb begin
      low_d      = low_q;
      high_d     = high_q;
      result_d   = result_q;
      sec_low_d  = sec_low_q;
      sec_high_d = sec_high_q;
      aux_d      = aux_q;
      if (reg_we_i) begin
         case (reg_waddr_i)
            LOW_PTR_ADDR:  low_d = reg_wdata_i; // see RL7
            HIGH_PTR_ADDR: high_d = reg_wdata_i; // see RL7
            RESULT_ADDR:   result_d = reg_wdata_i;
            SEC_LOW_ADDR:  sec_low_d = reg_wdata_i; // see RL11
            SEC_HIGH_ADDR: sec_high_d = reg_wdata_i; // see RL11
            AUX_ADDR:      aux_d = reg_wdata_i; // see RL10
            default:       aux_d = aux_q;
         endcase
      end
      // the look-up load wins over a bus write in the same cycle
      if (lookup) begin
         result_d = rom_word_i[15:8]; // see RL12
      end
   end

   // no reset here: these come up unknown and software sets them first
   always_ff @(posedge mclk_i) begin
      low_q      <= low_d; // see RL14
      high_q     <= high_d; // see RL14
      result_q   <= result_d; // see RL14
      sec_low_q  <= sec_low_d; // see RL14
      sec_high_q <= sec_high_d; // see RL14
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         aux_q <= AUX_RST; // see RL10
      end else begin
         aux_q <= aux_d;
      end
   end

   // registered answers toward the decoder and memory
   always_comb begin
      skip_d     = eval_skip;
      acc_we_d   = eval_to_acc | lookup;
      acc_data_d = lookup ? rom_word_i[7:0] : eval_result; // see RL12
      mem_we_d   = eval_to_mem; // see RL15
      mem_data_d = eval_result;
      rdata_d    = read_reg(reg_raddr_i, low_q, high_q, result_q, sec_low_q, sec_high_q, aux_q);
      if (ptr_sel_i) begin
         bank_d = sec_high_q; // see RL9
         loc_d  = sec_low_q; // see RL9
      end else begin
         bank_d = high_q; // see RL8
         loc_d  = low_q; // see RL8
      end
      rom_d = {sec_high_q, sec_low_q}; // see RL11
      // pointer bytes start unknown, so the pointer checks wait until each one was written
      ptr_written_d = ptr_written_q;
      if (reg_we_i) begin
         ptr_written_d = ptr_written_q | {reg_waddr_i == SEC_HIGH_ADDR, reg_waddr_i == SEC_LOW_ADDR,
                                          reg_waddr_i == HIGH_PTR_ADDR, reg_waddr_i == LOW_PTR_ADDR};
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         skip_q     <= 1'b0;
         acc_we_q   <= 1'b0;
         acc_data_q <= BYTE_MIN;
         mem_we_q   <= 1'b0;
         mem_data_q <= BYTE_MIN;
         rdata_q    <= BYTE_MIN;
         bank_q     <= BYTE_MIN;
         loc_q      <= BYTE_MIN;
         rom_q      <= 16'h0000;
         ptr_written_q <= 4'h0;
      end else begin
         ptr_written_q <= ptr_written_d;
         skip_q     <= skip_d;
         acc_we_q   <= acc_we_d;
         acc_data_q <= acc_data_d;
         mem_we_q   <= mem_we_d;
         mem_data_q <= mem_data_d;
         rdata_q    <= rdata_d;
         bank_q     <= bank_d;
         loc_q      <= loc_d;
         rom_q      <= rom_d;
      end
   end

   assign skip_o      = skip_q;
   assign acc_we_o    = acc_we_q;
   assign acc_data_o  = acc_data_q;
   assign mem_we_o    = mem_we_q;
   assign mem_data_o  = mem_data_q;
   assign reg_rdata_o = rdata_q;
   assign ram_bank_o  = bank_q;
   assign ram_loc_o   = loc_q;
   assign rom_addr_o  = rom_q;
   assign aux_ptr_o   = aux_q;

   compare_skip_a: assert property ( // see RL1
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == compare_skip_op && acc_i == operand_i
      |=> skip_o && pc_o == 13'($past(pc_o) + SKIP_STEP))
      else $error("compare match did not skip");

   inc_wrap_a: assert property ( // see RL2
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == inc_acc_skip_op && acc_i == BYTE_MAX
      |=> skip_o && acc_we_o && acc_data_o == BYTE_MIN)
      else $error("increment wrap did not skip");

   dec_wrap_a: assert property ( // see RL3
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == dec_mem_skip_op && operand_i == BYTE_MIN
      |=> skip_o && mem_we_o && mem_data_o == BYTE_MAX)
      else $error("decrement wrap did not skip");

   pcl_carry_a: assert property ( // see RL4
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == bank0_add_op && ({1'b0, pc_o[7:0]} + {1'b0, acc_i}) > 9'h0ff
      |=> pc_o[12:8] == 5'($past(pc_o[12:8]) + 5'h01))
      else $error("low byte carry lost");

   pch_hold_a: assert property ( // see RL5
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == op_sub_pcl
      |=> pc_o[12:8] == $past(pc_o[12:8]) && pc_o[7:0] == 8'($past(pc_o[7:0]) - $past(acc_i)))
      else $error("high byte moved on subtract");

   move_jump_a: assert property ( // see RL6
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == op_move_pcl
      |=> pc_o == {$past(pc_o[12:8]), $past(acc_i)})
      else $error("move into low byte jumped wrong");

   ptr_route_a: assert property ( // see RL8
      @(posedge mclk_i) disable iff (rst_i)
      &ptr_written_q[1:0] && !ptr_sel_i ##1 !ptr_sel_i
      |-> ram_bank_o == $past(high_q) && ram_loc_o == $past(low_q))
      else $error("first pointer routed wrong");

   sec_route_a: assert property ( // see RL9
      @(posedge mclk_i) disable iff (rst_i)
      &ptr_written_q[3:2] && ptr_sel_i ##1 ptr_sel_i
      |-> ram_bank_o == $past(sec_high_q) && ram_loc_o == $past(sec_low_q))
      else $error("second pointer routed wrong");

   rom_ptr_a: assert property ( // see RL11
      @(posedge mclk_i) disable iff (rst_i)
      &ptr_written_q[3:2]
      |=> rom_addr_o == {$past(sec_high_q), $past(sec_low_q)})
      else $error("rom pointer formed wrong");

   high_read_a: assert property ( // see RL7
      @(posedge mclk_i) disable iff (rst_i)
      ptr_written_q[1] && reg_raddr_i == HIGH_PTR_ADDR
      |=> reg_rdata_o == $past(high_q))
      else $error("high pointer read back wrong");

   aux_clear_a: assert property ( // see RL10
      @(posedge mclk_i)
      $fell(rst_i) |-> aux_ptr_o == AUX_RST)
      else $error("auxiliary pointer not cleared");

   lookup_split_a: assert property ( // see RL12
      @(posedge mclk_i) disable iff (rst_i)
      lookup
      |=> result_q == $past(rom_word_i[15:8]) && acc_we_o && acc_data_o == $past(rom_word_i[7:0]))
      else $error("look-up split wrong");

   jump_load_a: assert property ( // see RL13
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == op_jump |=> pc_o == $past(jump_addr_i))
      else $error("jump not loaded");

   one_slot_a: assert property ( // see RL15
      @(posedge mclk_i) disable iff (rst_i)
      op_valid_i && op_i == dec_acc_skip_op
      |=> acc_we_o && skip_o == ($past(acc_i) == BYTE_MIN)
          && (pc_o == 13'($past(pc_o) + (($past(acc_i) == BYTE_MIN) ? SKIP_STEP : STEP))))
      else $error("skip slot count or write wrong");

endmodule

// ---- core_model.sv ----
`timescale 1ns/1ps
module core_model (
   input  wire logic [15:0] rom_addr_i,
   output logic      [15:0] rom_word_o
);
   // program memory: a scramble of the address, so that each address returns a different word
   // the high byte comes from the low address byte and the low byte from the high one; a swapped split shows up unless both match
   assign rom_word_o = {rom_addr_i[7:0] ^ 8'h5a, rom_addr_i[15:8] + 8'h3c};
endmodule

// ---- pc_skip_and_pointer_regs_test.sv ----
`timescale 1ns/1ps
module pc_skip_and_pointer_regs_test;
   import pc_skip_pkg::*;
   logic        mclk_i;
   logic        rst_i;
   logic        op_valid_i;
   op_type      op_i;
   logic [7:0]  acc_i;
   logic [7:0]  operand_i;
   logic        carry_i;
   logic [12:0] jump_addr_i;
   logic [15:0] rom_word_i;
   logic        reg_we_i;
   logic [7:0]  reg_waddr_i;
   logic [7:0]  reg_wdata_i;
   logic [7:0]  reg_raddr_i;
   logic        ptr_sel_i;
   logic [12:0] pc_o;
   logic        skip_o;
   logic        acc_we_o;
   logic [7:0]  acc_data_o;
   logic        mem_we_o;
   logic [7:0]  mem_data_o;
   logic [7:0]  reg_rdata_o;
   logic [7:0]  ram_bank_o;
   logic [7:0]  ram_loc_o;
   logic [15:0] rom_addr_o;
   logic [7:0]  aux_ptr_o;
   int          n_fail;
   int          cmp_count;
   int          pc;
   logic [7:0]  regs [6];

   pc_skip_and_pointer_regs u_dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i), .acc_i(acc_i),
      .operand_i(operand_i), .carry_i(carry_i), .jump_addr_i(jump_addr_i), .rom_word_i(rom_word_i),
      .reg_we_i(reg_we_i), .reg_waddr_i(reg_waddr_i), .reg_wdata_i(reg_wdata_i), .reg_raddr_i(reg_raddr_i),
      .ptr_sel_i(ptr_sel_i), .pc_o(pc_o), .skip_o(skip_o), .acc_we_o(acc_we_o), .acc_data_o(acc_data_o),
      .mem_we_o(mem_we_o), .mem_data_o(mem_data_o), .reg_rdata_o(reg_rdata_o), .ram_bank_o(ram_bank_o),
      .ram_loc_o(ram_loc_o), .rom_addr_o(rom_addr_o), .aux_ptr_o(aux_ptr_o)
   );

   core_model u_core (
      .rom_addr_i(rom_addr_o),
      .rom_word_o(rom_word_i)
   );

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one instruction: drive, predict, check the answer one edge later
   task automatic run_op(input op_type op, input logic [7:0] a, input logic [7:0] m, input logic c,
                         input logic v, input logic [12:0] j);
      int r;
      int sk;
      int aw;
      int mw;
      int hi;
      int lo;
      int nx;
      logic [15:0] rw;
      op_i = op;
      acc_i = a;
      operand_i = m;
      carry_i = c;
      op_valid_i = v;
      jump_addr_i = j;
      #1 rw = rom_word_i;
      r = 0; sk = 0; aw = 0; mw = 0;
      hi = (pc >> 8) & 31;
      lo = pc & 255;
      nx = pc + 1;
      if (!v || op == op_hold) nx = pc;
      else case (op)
         compare_skip_op: sk = int'(a == m);
         inc_acc_skip_op: begin r = (int'(a) + 1) & 255; sk = int'(r == 0); aw = 1; end
         inc_mem_skip_op: begin r = (int'(m) + 1) & 255; sk = int'(r == 0); mw = 1; end
         dec_acc_skip_op: begin r = (int'(a) - 1) & 255; sk = int'(a == 0); aw = 1; end
         dec_mem_skip_op: begin r = (int'(m) - 1) & 255; sk = int'(m == 0); mw = 1; end
         op_add_pcl, bank0_add_op, op_adc_pcl: begin
            lo = lo + int'(a) + ((op == op_adc_pcl) ? int'(c) : 0);
            nx = (((hi + (lo >> 8)) & 31) << 8) | (lo & 255);
         end
         op_sub_pcl: nx = (hi << 8) | ((lo - int'(a)) & 255);
         op_move_pcl: nx = (hi << 8) | int'(a);
         op_jump: nx = int'(j);
         table_lookup_op: begin r = int'(rw[7:0]); aw = 1; regs[2] = rw[15:8]; end
         default: nx = pc + 1;
      endcase
      if (sk != 0) nx = pc + 2;
      nx = nx & 8191;
      @(posedge mclk_i);
      #1;
      check("pc", pc_o, 16'(nx));
      check("skip", skip_o, 16'(sk));
      check("acc_we", acc_we_o, 16'(aw));
      if (aw != 0) check("acc_data", acc_data_o, 16'(r));
      check("mem_we", mem_we_o, 16'(mw));
      if (mw != 0) check("mem_data", mem_data_o, 16'(r));
      pc = nx;
   endtask

   // leaves the strobe high so back-to-back writes never assign it twice in one step
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      reg_we_i = 1'b1;
      reg_waddr_i = ad;
      reg_wdata_i = d;
      @(posedge mclk_i);
      #1;
      if (ad >= LOW_PTR_ADDR && ad <= AUX_ADDR) regs[ad - LOW_PTR_ADDR] = d;
   endtask

   task automatic rd(input logic [7:0] ad);
      reg_raddr_i = ad;
      @(posedge mclk_i);
      #1;
      check("rdata", reg_rdata_o, (ad >= LOW_PTR_ADDR && ad <= AUX_ADDR) ? regs[ad - LOW_PTR_ADDR] : UNMAPPED);
   endtask

   task automatic ptrs(input logic s);
      ptr_sel_i = s;
      repeat (2) @(posedge mclk_i);
      #1;
      check("bank", ram_bank_o, s ? regs[4] : regs[1]);
      check("loc", ram_loc_o, s ? regs[3] : regs[0]);
      check("rom_addr", rom_addr_o, {regs[4], regs[3]});
      check("aux", aux_ptr_o, regs[5]);
   endtask

   initial begin
      #50000;
      n_fail++;
      conclude();
   end

   initial begin
      rst_i = 1'b1; op_valid_i = 1'b0; op_i = op_hold; acc_i = 8'h00; operand_i = 8'h00;
      carry_i = 1'b0; jump_addr_i = 13'h0000; reg_we_i = 1'b0; reg_waddr_i = 8'h00;
      reg_wdata_i = 8'h00; reg_raddr_i = 8'h00; ptr_sel_i = 1'b0;
      n_fail = 0; cmp_count = 0; pc = 0; regs[5] = AUX_RST;
      void'($urandom(63));
      repeat (8) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      check("pc_rst", pc_o, PC_RST);
      rd(AUX_ADDR);
      rd(8'h86);
      $display("test reset done");
      for (int i = 0; i < 6; i++) wr(LOW_PTR_ADDR + 8'(i), 8'($urandom));
      wr(8'h86, 8'h77);
      reg_we_i = 1'b0;
      for (int i = 0; i < 7; i++) rd(LOW_PTR_ADDR + 8'(i));
      ptrs(1'b0);
      ptrs(1'b1);
      $display("test registers done");
      run_op(op_jump, 8'h00, 8'h00, 1'b0, 1'b1, 13'h0323);
      run_op(op_move_pcl, 8'hf0, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(op_add_pcl, 8'h20, 8'h00, 1'b1, 1'b1, 13'h0000);
      run_op(op_adc_pcl, 8'h0f, 8'h00, 1'b1, 1'b1, 13'h0000);
      run_op(op_sub_pcl, 8'h30, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(bank0_add_op, 8'h1f, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(op_jump, 8'h00, 8'h00, 1'b0, 1'b1, 13'h1ff0);
      run_op(op_add_pcl, 8'h20, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(compare_skip_op, 8'h12, 8'h12, 1'b0, 1'b1, 13'h0000);
      run_op(compare_skip_op, 8'h12, 8'h13, 1'b0, 1'b1, 13'h0000);
      run_op(inc_acc_skip_op, BYTE_MAX, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(inc_acc_skip_op, 8'h7f, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(inc_mem_skip_op, 8'h00, BYTE_MAX, 1'b0, 1'b1, 13'h0000);
      run_op(dec_acc_skip_op, BYTE_MIN, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(dec_mem_skip_op, 8'h00, BYTE_MIN, 1'b0, 1'b1, 13'h0000);
      run_op(dec_mem_skip_op, 8'h00, BYTE_ONE, 1'b0, 1'b1, 13'h0000);
      run_op(op_hold, 8'h00, 8'h00, 1'b0, 1'b1, 13'h0000);
      run_op(op_step, 8'h00, 8'h00, 1'b0, 1'b0, 13'h0000);
      run_op(op_step, 8'h00, 8'h00, 1'b0, 1'b1, 13'h0000);
      reg_we_i = 1'b1;
      reg_waddr_i = RESULT_ADDR;
      run_op(table_lookup_op, 8'h00, 8'h00, 1'b0, 1'b1, 13'h0000);
      reg_we_i = 1'b0;
      op_valid_i = 1'b0;
      rd(RESULT_ADDR);
      $display("test directed ops done");
      for (int i = 0; i < 300; i++)
         run_op(op_type'(4'($urandom_range(13))), 8'($urandom), 8'($urandom), 1'($urandom),
                1'($urandom_range(7) != 0), 13'($urandom));
      op_valid_i = 1'b0;
      rd(RESULT_ADDR);
      ptrs(1'b1);
      $display("test random ops done");
      rst_i = 1'b1;
      #1;
      check("pc_rst", pc_o, PC_RST);
      check("aux_rst", aux_ptr_o, AUX_RST);
      check("skip_rst", skip_o, 16'h0000);
      @(posedge mclk_i);
      #1 rst_i = 1'b0;
      pc = 0;
      regs[5] = AUX_RST;
      rd(AUX_ADDR);
      $display("test second reset done");
      conclude();
   end
endmodule
